// ---- logic/assr_cfg.svh ----
// constants for the accelerometer sample status and data registers
`ifndef ASSR_CFG_SVH
`define ASSR_CFG_SVH

// register offsets
`define ASSR_STATUS_OFS 8'h00
`define ASSR_X_HI_OFS 8'h01
`define ASSR_X_LO_OFS 8'h02
`define ASSR_Y_HI_OFS 8'h03
`define ASSR_Y_LO_OFS 8'h04
`define ASSR_Z_HI_OFS 8'h05
`define ASSR_Z_LO_OFS 8'h06

// reset values and field layout
`define ASSR_STATUS_RST 8'h00
`define ASSR_SMP_W 12
`define ASSR_HI_MSB 11
`define ASSR_HI_LSB 4
`define ASSR_LO_MSB 3

// sample fifo: {axes new, z, y, x}
`define ASSR_FIFO_W 39
`define ASSR_FIFO_D 16

// serial bus slave address, arbitrary value
`define ASSR_I2C_ADDR 7'h3c
`define ASSR_BYTE_BITS 4'h8
`define ASSR_LAST_BIT 4'h7

`endif

// ---- logic/assr_fifo.sv ----
// parameterised valid/ready fifo for the sample stream
`timescale 1ns/10ps
module assr_fifo #(
   parameter int W = 39,
   parameter int D = 16
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } assr_fifo_st_t;

   assr_fifo_st_t s_q, s_d;
   logic full, empty;

   assign empty = (s_q.wp == s_q.rp);
   assign full = (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]) &&
                 (s_q.wp[AW] != s_q.rp[AW]);
   assign in_ready_o = ~full;
   assign out_valid_o = ~empty;
   assign out_data_o = s_q.mem[s_q.rp[AW-1:0]];

   always_comb begin
      s_d = s_q;
      if (in_valid_i && !full) begin
         s_d.mem[s_q.wp[AW-1:0]] = in_data_i;
         s_d.wp = s_q.wp + 1'b1;
      end
      if (out_ready_i && !empty) begin
         s_d.rp = s_q.rp + 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule // assr_fifo

// ---- logic/assr_pkg.sv ----
// types shared by the sample status register block
package assr_pkg;
   typedef enum logic [3:0] {
      I_IDLE, I_ADDR, I_AACK, I_REG, I_REGACK,
      I_WDAT, I_WACK, I_RDAT, I_MACK
   } assr_i2c_st_t;

   typedef logic [2:0] assr_axes_t;
   typedef logic [11:0] assr_smp_t;
endpackage

// ---- logic/assr_top.sv ----
// sample status flags, axis data registers and their serial read port
`timescale 1ns/10ps
`include "assr_cfg.svh"

// Function
// - status register: overwrite and ready flags
// - combined overwrite sets on any overwrite
// - combined overwrite clears after enabled highs read
// - axis overwrite sets on unread replacement
// - axis overwrite clears on its high read
// - combined ready sets on any new sample for an enabled axis
// - combined ready clears after enabled highs read
// - axis ready sets on sample, clears on high
// - all status flags zero after reset
// - axis data is 12-bit two's complement
// - status and data auto-increment, seven bytes
// - fast read skips low bytes
// - low byte only right after high
// - high and low from same sample
// - standby to active clears data, flags
// - high bits 11..4, low bits 3..0 upper
// - stop discards auto-increment address
module assr_top (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // serial bus, open drain data
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // control bits held elsewhere
   input wire logic fast_read_i,
   input wire logic active_i,
   input wire assr_pkg::assr_axes_t axis_en_i,
   // sample stream
   input wire logic sample_valid_i,
   output logic sample_ready_o,
   input wire assr_pkg::assr_axes_t sample_axes_i,
   input wire assr_pkg::assr_smp_t x_sample_i,
   input wire assr_pkg::assr_smp_t y_sample_i,
   input wire assr_pkg::assr_smp_t z_sample_i
);
   import assr_pkg::*;

   typedef struct packed {
      assr_i2c_st_t st;
      logic scl_q;
      logic sda_q;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic rw;
      logic nack;
      logic oe;
      logic [7:0] reg_addr;
      logic [1:0] hi_axis;
      logic [3:0] lo_hold;
      logic [2:0][11:0] smp;
      logic [2:0] rdy;
      logic [2:0] ow;
      logic all_rdy;
      logic all_ow;
      logic act_q;
   } assr_st_t;

   assr_st_t s_q, s_d;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // auto-increment order; fast mode jumps over low bytes
   function automatic logic [7:0] next_addr(input logic [7:0] a,
                                            input logic fast);
      logic [7:0] r;
      r = a + 8'h01;
      case (a)
         `ASSR_X_HI_OFS: r = fast ? `ASSR_Y_HI_OFS : `ASSR_X_LO_OFS;
         `ASSR_Y_HI_OFS: r = fast ? `ASSR_Z_HI_OFS : `ASSR_Y_LO_OFS;
         `ASSR_Z_HI_OFS: r = fast ? `ASSR_STATUS_OFS : `ASSR_Z_LO_OFS;
         `ASSR_Z_LO_OFS: r = `ASSR_STATUS_OFS;
         default: r = a + 8'h01;
      endcase
      return r;
   endfunction

   function automatic logic is_high(input logic [7:0] a);
      return (a == `ASSR_X_HI_OFS) || (a == `ASSR_Y_HI_OFS) ||
             (a == `ASSR_Z_HI_OFS);
   endfunction

   // ----------------------------------------------------------------
   // sample fifo
   // ----------------------------------------------------------------
   logic f_valid, pop, fetch;
   logic [`ASSR_FIFO_W-1:0] f_data;

   assr_fifo #(
      .W(`ASSR_FIFO_W),
      .D(`ASSR_FIFO_D)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(sample_valid_i),
      .in_ready_o(sample_ready_o),
      .in_data_i({sample_axes_i, z_sample_i, y_sample_i, x_sample_i}),
      .out_valid_o(f_valid),
      .out_ready_i(pop),
      .out_data_o(f_data)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   logic rise, fall, start, stop;
   logic [7:0] rd_byte;

   assign rise = ~s_q.scl_q & scl_i;
   assign fall = s_q.scl_q & ~scl_i;
   assign start = s_q.scl_q & scl_i & s_q.sda_q & ~sda_i;
   assign stop = s_q.scl_q & scl_i & ~s_q.sda_q & sda_i;
   // the drain stalls on a read fetch so a read's flag clear and a sample's flag set never mix
   assign pop = f_valid & ~fetch;

   always_comb begin
      s_d = s_q;
      s_d.scl_q = scl_i;
      s_d.sda_q = sda_i;
      fetch = 1'b0;
      rd_byte = 8'h00;
      // register read mux
      case (s_q.reg_addr)
         `ASSR_STATUS_OFS: rd_byte = {s_q.all_ow, s_q.ow,
                                      s_q.all_rdy, s_q.rdy};
         `ASSR_X_HI_OFS: rd_byte = s_q.smp[0][11:4];
         `ASSR_Y_HI_OFS: rd_byte = s_q.smp[1][11:4];
         `ASSR_Z_HI_OFS: rd_byte = s_q.smp[2][11:4];
         `ASSR_X_LO_OFS: rd_byte = (s_q.hi_axis == 2'h0) ?
                                   {s_q.lo_hold, 4'h0} : 8'h00;
         `ASSR_Y_LO_OFS: rd_byte = (s_q.hi_axis == 2'h1) ?
                                   {s_q.lo_hold, 4'h0} : 8'h00;
         `ASSR_Z_LO_OFS: rd_byte = (s_q.hi_axis == 2'h2) ?
                                   {s_q.lo_hold, 4'h0} : 8'h00;
         default: rd_byte = 8'h00;
      endcase

      // serial bus slave
      if (stop) begin
         s_d.st = I_IDLE;
         s_d.oe = 1'b0;
         s_d.reg_addr = `ASSR_STATUS_OFS;
      end else if (start) begin
         s_d.st = I_ADDR;
         s_d.cnt = 4'h0;
         s_d.oe = 1'b0;
      end else if (rise) begin
         case (s_q.st)
            I_ADDR, I_REG, I_WDAT: begin
               s_d.sh = {s_q.sh[6:0], sda_i};
               s_d.cnt = s_q.cnt + 4'h1;
            end
            I_MACK: s_d.nack = sda_i;
            default: s_d.st = s_q.st;
         endcase
      end else if (fall) begin
         case (s_q.st)
            I_ADDR: begin
               if (s_q.cnt == `ASSR_BYTE_BITS) begin
                  if (s_q.sh[7:1] == `ASSR_I2C_ADDR) begin
                     s_d.st = I_AACK;
                     s_d.rw = s_q.sh[0];
                     s_d.oe = 1'b1;
                  end else begin
                     s_d.st = I_IDLE;
                  end
               end
            end
            I_AACK: begin
               s_d.cnt = 4'h0;
               if (s_q.rw) begin
                  fetch = 1'b1;
               end else begin
                  s_d.st = I_REG;
                  s_d.oe = 1'b0;
               end
            end
            I_REG: begin
               if (s_q.cnt == `ASSR_BYTE_BITS) begin
                  s_d.reg_addr = s_q.sh;
                  s_d.st = I_REGACK;
                  s_d.oe = 1'b1;
               end
            end
            I_WDAT: begin
               // data bytes are acknowledged and dropped
               if (s_q.cnt == `ASSR_BYTE_BITS) begin
                  s_d.st = I_WACK;
                  s_d.oe = 1'b1;
               end
            end
            I_REGACK, I_WACK: begin
               s_d.st = I_WDAT;
               s_d.cnt = 4'h0;
               s_d.oe = 1'b0;
            end
            I_RDAT: begin
               if (s_q.cnt == `ASSR_LAST_BIT) begin
                  s_d.st = I_MACK;
                  s_d.oe = 1'b0;
               end else begin
                  s_d.cnt = s_q.cnt + 4'h1;
                  s_d.sh = {s_q.sh[6:0], 1'b0};
                  s_d.oe = ~s_q.sh[6];
               end
            end
            I_MACK: begin
               s_d.cnt = 4'h0;
               if (s_q.nack) begin
                  s_d.st = I_IDLE;
               end else begin
                  fetch = 1'b1;
               end
            end
            default: s_d.st = s_q.st;
         endcase
      end

      // a read access: load byte, side effects, advance address
      if (fetch) begin
         s_d.st = I_RDAT;
         s_d.sh = rd_byte;
         s_d.oe = ~rd_byte[7];
         s_d.reg_addr = next_addr(s_q.reg_addr, fast_read_i);
         s_d.hi_axis = 2'h3;
         case (s_q.reg_addr)
            `ASSR_X_HI_OFS: begin
               s_d.hi_axis = 2'h0;
               s_d.lo_hold = s_q.smp[0][3:0];
               s_d.rdy[0] = 1'b0;
               s_d.ow[0] = 1'b0;
            end
            `ASSR_Y_HI_OFS: begin
               s_d.hi_axis = 2'h1;
               s_d.lo_hold = s_q.smp[1][3:0];
               s_d.rdy[1] = 1'b0;
               s_d.ow[1] = 1'b0;
            end
            `ASSR_Z_HI_OFS: begin
               s_d.hi_axis = 2'h2;
               s_d.lo_hold = s_q.smp[2][3:0];
               s_d.rdy[2] = 1'b0;
               s_d.ow[2] = 1'b0;
            end
            default: s_d.hi_axis = 2'h3;
         endcase
         if (is_high(s_q.reg_addr) && ((s_d.rdy & axis_en_i) == 3'h0)) begin
            s_d.all_rdy = 1'b0;
            s_d.all_ow = 1'b0;
         end
      end

      // standby to active wipes flags and data
      s_d.act_q = active_i;
      if (active_i && !s_q.act_q) begin
         s_d.smp = '0;
         s_d.rdy = 3'h0;
         s_d.ow = 3'h0;
         s_d.all_rdy = 1'b0;
         s_d.all_ow = 1'b0;
         s_d.lo_hold = 4'h0;
      end

      // new samples come last so a set beats a same-cycle clear
      if (pop) begin
         for (int i = 0; i < 3; i++) begin
            if (f_data[36+i] && axis_en_i[i]) begin
               if (s_d.rdy[i]) begin
                  s_d.ow[i] = 1'b1;
                  s_d.all_ow = 1'b1;
               end
               s_d.rdy[i] = 1'b1;
               s_d.all_rdy = 1'b1;
               s_d.smp[i] = f_data[i*12 +: 12];
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_q <= '0;
         s_q.st <= I_IDLE;
         s_q.scl_q <= 1'b1;
         s_q.sda_q <= 1'b1;
         s_q.hi_axis <= 2'h3;
      end else begin
         s_q <= s_d;
      end
   end

   // open drain: only ever pull low
   assign sda_o = 1'b0;
   assign sda_oe_o = s_q.oe;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   logic [7:0] status_v;
   assign status_v = {s_q.all_ow, s_q.ow, s_q.all_rdy, s_q.rdy};

   reset_flags_a: assert property ($past(sys_rst_i) |->
      status_v == `ASSR_STATUS_RST) else $error("flags not clear");
   ready_set_a: assert property (pop && f_data[36] && axis_en_i[0]
      |=> s_q.rdy[0] && s_q.all_rdy) else $error("x ready not set");
   ow_set_a: assert property (pop && f_data[37] && axis_en_i[1]
      && s_q.rdy[1] && !(active_i && !s_q.act_q)
      |=> s_q.ow[1] && s_q.all_ow) else $error("y overwrite lost");
   hi_clear_a: assert property (fetch &&
      s_q.reg_addr == `ASSR_Z_HI_OFS && !pop && s_q.act_q
      |=> !s_q.rdy[2] && !s_q.ow[2]) else $error("z flags kept");
   all_clear_a: assert property (fetch && is_high(s_q.reg_addr)
      && s_q.act_q && ((s_d.rdy & axis_en_i) == 3'h0)
      |=> !s_q.all_rdy && !s_q.all_ow) else $error("combined kept");
   // the pair holds because the latched nibble only moves on a high fetch or a standby to active wipe
   low_pair_a: assert property (fetch &&
      s_q.reg_addr == `ASSR_X_HI_OFS && !(active_i && !s_q.act_q)
      |=> s_q.lo_hold == $past(s_q.smp[0][3:0]) && s_q.hi_axis == 2'h0)
      else $error("pair not latched");
   hold_keep_a: assert property (!fetch &&
      !(active_i && !s_q.act_q) |=> $stable(s_q.lo_hold))
      else $error("held low byte moved");
   low_random_a: assert property (fetch &&
      s_q.reg_addr == `ASSR_Y_LO_OFS && s_q.hi_axis != 2'h1
      |=> s_q.sh == 8'h00) else $error("random low read");
   fast_skip_a: assert property (fetch && fast_read_i &&
      s_q.reg_addr == `ASSR_X_HI_OFS
      |=> s_q.reg_addr == `ASSR_Y_HI_OFS) else $error("no skip");
   wrap_a: assert property (fetch && !fast_read_i &&
      s_q.reg_addr == `ASSR_Z_LO_OFS
      |=> s_q.reg_addr == `ASSR_STATUS_OFS) else $error("no wrap");
   stop_addr_a: assert property (stop
      |=> s_q.reg_addr == `ASSR_STATUS_OFS) else $error("addr kept");
   activate_a: assert property ($rose(active_i) && !pop
      |=> status_v == 8'h00 && s_q.smp == '0) else $error("no wipe");
   wr_ign_a: assert property (s_q.st == I_WDAT && !pop &&
      !(active_i && !s_q.act_q) |=> $stable(s_q.smp) &&
      $stable(s_q.rdy)) else $error("write changed data");

   burst_c: cover property (fetch && s_q.reg_addr == `ASSR_Z_LO_OFS);
   fast_c: cover property (fetch && fast_read_i &&
      s_q.reg_addr == `ASSR_Z_HI_OFS);
   ovw_c: cover property (s_q.all_ow);
   nack_c: cover property (s_q.st == I_MACK && fall && s_q.nack);
endmodule // assr_top

// ---- sim/assr_host.sv ----
// serial bus host model that reads and writes the sample registers
`timescale 1ns/10ps
`include "assr_cfg.svh"
module assr_host (
   // clock
   input wire logic clk_sys_i,
   // open drain serial bus
   output logic scl_o,
   output logic sda_oe_o,
   input wire logic sda_i
);
   logic [7:0] tmp;
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   // half period of five clocks keeps above the device minimum of four
   task automatic hp();
      repeat (5) @(posedge clk_sys_i);
   endtask
   // also serves as repeated start
   task automatic start();
      @(posedge clk_sys_i);
      sda_oe_o <= 1'b0;
      hp();
      scl_o <= 1'b1;
      hp();
      sda_oe_o <= 1'b1;
      hp();
      scl_o <= 1'b0;
   endtask
   task automatic stop();
      @(posedge clk_sys_i);
      sda_oe_o <= 1'b1;
      hp();
      scl_o <= 1'b1;
      hp();
      sda_oe_o <= 1'b0;
      hp();
   endtask
   // eight data clocks then the acknowledge clock; data moves one
   // clock after scl falls so it never looks like start or stop
   task automatic io(input logic [7:0] tx, input logic ackm,
                     output logic [7:0] rx);
      logic [8:0] sh;
      logic [8:0] r;
      sh = {tx, ackm};
      for (int i = 8; i >= 0; i--) begin
         @(posedge clk_sys_i);
         sda_oe_o <= ~sh[i];
         hp();
         scl_o <= 1'b1;
         hp();
         r[i] = sda_i;
         scl_o <= 1'b0;
      end
      rx = r[8:1];
   endtask
   task automatic rd(input logic [7:0] ra, input bit setreg, input int n,
                     output logic [7:0] d [8]);
      if (setreg) begin
         start();
         io({`ASSR_I2C_ADDR, 1'b0}, 1'b1, tmp);
         io(ra, 1'b1, tmp);
      end
      start();
      io({`ASSR_I2C_ADDR, 1'b1}, 1'b1, tmp);
      for (int k = 0; k < n; k++)
         io(8'hff, k == n - 1, d[k]);
      stop();
   endtask
   task automatic wr(input logic [7:0] ra, input logic [7:0] wd);
      start();
      io({`ASSR_I2C_ADDR, 1'b0}, 1'b1, tmp);
      io(ra, 1'b1, tmp);
      io(wd, 1'b1, tmp);
      stop();
   endtask
endmodule // assr_host

// ---- sim/tb_top.sv ----
// self-checking bench for the sample status and data registers
`timescale 1ns/10ps
module tb_top;
   import assr_pkg::*;
   localparam assr_smp_t XA = 12'h9ab, YA = 12'h123, ZA = 12'h8f0;
   localparam assr_smp_t XB = 12'h7c5, YB = 12'hfe1, ZB = 12'h046;
   localparam assr_smp_t XC = 12'h001, YC = 12'h800, ZC = 12'h7ff;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic scl, host_oe, sda_o, dev_oe, sda, sample_ready;
   logic fast_read = 1'b0, active = 1'b0, sample_valid = 1'b0;
   assr_axes_t axis_en = 3'h7, sample_axes = 3'h0;
   assr_smp_t xs = 12'h000, ys = 12'h000, zs = 12'h000;
   logic [7:0] rb [8];
   logic [63:0] e;
   int cnt;
   int n_fail = 0;
   int n_tests = 0;

   always #5 clk_sys_i = ~clk_sys_i;
   // pull-up: the wire is low only while someone pulls it
   assign sda = !(host_oe || (dev_oe && !sda_o));

   assr_top uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(dev_oe),
      .fast_read_i(fast_read), .active_i(active), .axis_en_i(axis_en),
      .sample_valid_i(sample_valid), .sample_ready_o(sample_ready),
      .sample_axes_i(sample_axes), .x_sample_i(xs), .y_sample_i(ys),
      .z_sample_i(zs));
   assr_host host (.clk_sys_i(clk_sys_i), .scl_o(scl),
      .sda_oe_o(host_oe), .sda_i(sda));

   function automatic logic [7:0] hi(assr_smp_t s);
      return s[11:4];
   endfunction
   function automatic logic [7:0] lo(assr_smp_t s);
      return {s[3:0], 4'h0};
   endfunction
   task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic push(assr_axes_t a, assr_smp_t x, y, z);
      int k = 0;
      @(posedge clk_sys_i);
      sample_valid <= 1'b1;
      sample_axes <= a;
      xs <= x;
      ys <= y;
      zs <= z;
      do begin
         @(negedge clk_sys_i);
         k++;
      end while (sample_ready !== 1'b1 && k < 20);
      if (sample_ready !== 1'b1) begin
         n_fail++;
         summarize();
      end
      @(posedge clk_sys_i);
      sample_valid <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
   endtask
   // expected bytes are right aligned in ex, first byte leftmost
   task automatic rdc(logic [7:0] ra, bit s, int n, logic [63:0] ex,
                      string nm);
      host.rd(ra, s, n, rb);
      for (int k = 0; k < n; k++)
         chk(nm, rb[k], ex[8 * (n - 1 - k) +: 8]);
   endtask

   initial begin
      repeat (6) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      active <= 1'b1;
      rdc(8'h00, 0, 7, 64'h0, "reset");
      push(3'b001, XA, YA, ZA);
      rdc(8'h00, 1, 1, 64'h09, "x only");
      rdc(8'h01, 1, 1, 64'(hi(XA)), "x high");
      rdc(8'h00, 1, 1, 64'h00, "x read");
      push(3'b111, XA, YA, ZA);
      push(3'b111, XB, YB, ZB);
      rdc(8'h03, 1, 1, 64'(hi(YB)), "y high");
      rdc(8'h00, 1, 1, 64'hdd, "y read");
      e = {8'h00, 8'hdd, hi(XB), lo(XB), hi(YB), lo(YB), hi(ZB), lo(ZB)};
      rdc(8'h00, 0, 7, e, "burst");
      rdc(8'h00, 1, 1, 64'h00, "all read");
      push(3'b111, XC, YC, ZC);
      host.wr(8'h00, 8'h00);
      host.wr(8'h01, 8'h00);
      rdc(8'h00, 1, 3, {40'h0, 8'h0f, hi(XC), lo(XC)}, "write");
      rdc(8'h02, 1, 1, 64'h0, "random low");
      rdc(8'h07, 1, 1, 64'h0, "unmapped");
      // a new sample lands between the high and low fetches
      fork
         rdc(8'h01, 1, 2, {48'h0, hi(XC), lo(XC)}, "pair");
         begin
            repeat (380) @(posedge clk_sys_i);
            push(3'b111, XA, YA, ZA);
         end
      join
      @(posedge clk_sys_i);
      fast_read <= 1'b1;
      e = {32'h0, 8'hef, hi(XA), hi(YA), hi(ZA)};
      rdc(8'h00, 1, 4, e, "fast");
      push(3'b111, XB, YB, ZB);
      @(posedge clk_sys_i);
      active <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      active <= 1'b1;
      fast_read <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      rdc(8'h00, 1, 3, 64'h0, "mode change");
      // back-to-back words must drain in order, the last one standing
      @(posedge clk_sys_i);
      sample_valid <= 1'b1;
      sample_axes <= 3'h7;
      for (cnt = 0; cnt < 3; cnt++) begin
         xs <= (cnt == 0) ? XA : (cnt == 1) ? XB : XC;
         ys <= (cnt == 0) ? YA : (cnt == 1) ? YB : YC;
         zs <= (cnt == 0) ? ZA : (cnt == 1) ? ZB : ZC;
         @(negedge clk_sys_i);
         chk("fifo ready", {7'h00, sample_ready}, 8'h01);
         @(posedge clk_sys_i);
      end
      sample_valid <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      e = {8'h00, 8'hff, hi(XC), lo(XC), hi(YC), lo(YC), hi(ZC), lo(ZC)};
      rdc(8'h00, 1, 7, e, "fifo order");
      rdc(8'h00, 1, 1, 64'h00, "fifo clear");
      // a disabled axis keeps its old data and leaves the flags alone
      axis_en <= 3'h3;
      push(3'b111, XA, YA, ZA);
      e = {32'h0, 8'h0b, hi(XA), lo(XA), hi(YA)};
      rdc(8'h00, 1, 4, e, "enabled only");
      rdc(8'h00, 1, 1, 64'h00, "enabled read");
      rdc(8'h05, 1, 1, 64'(hi(ZC)), "disabled axis");
      summarize();
   end
endmodule // tb_top
